// ===== include/ssc_pkg.sv
// package: offsets, field positions, reset values and carriers of the sync select register bank
package ssc_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] OFS_SRC_SEL   = 8'h12;
   localparam logic [7:0] OFS_SEP_THR   = 8'h13;
   localparam logic [7:0] OFS_CTL       = 8'h14;
   localparam logic [7:0] OFS_POL_STAT  = 8'h15;
   localparam logic [7:0] OFS_SLICER    = 8'h16;
   localparam logic [7:0] OFS_LEAD      = 8'h17;
   localparam logic [7:0] OFS_TRAIL     = 8'h18;
   localparam logic [7:0] OFS_TEST_A    = 8'h19;
   localparam logic [7:0] OFS_TEST_B    = 8'h1A;
   localparam logic [7:0] OFS_TEST_C    = 8'h1B;
   localparam logic [7:0] OFS_TEST_FMT  = 8'h1C;

   // ****************************************
   // field positions
   // ****************************************
   localparam int BIT_HS_OVR    = 5;
   localparam int BIT_HS_SEL    = 4;
   localparam int BIT_VS_OVR    = 3;
   localparam int BIT_VS_SEL    = 2;
   localparam int BIT_HOLD_SEL  = 1;
   localparam int BIT_PWR_N     = 0;
   localparam int BIT_SCAN_EN   = 2;
   localparam int BIT_HOLD_POVR = 1;
   localparam int BIT_HS_POVR   = 0;
   localparam int BIT_STAT_HS   = 7;
   localparam int BIT_STAT_VS   = 6;
   localparam int BIT_STAT_HOLD = 5;
   localparam int SLC_MSB       = 7;
   localparam int SLC_LSB       = 3;
   localparam int BIT_FMT_422   = 1;

   // ****************************************
   // values after reset
   // ****************************************
   localparam logic [7:0] RST_SRC_SEL  = 8'h01;
   localparam logic [7:0] RST_SEP_THR  = 8'h20;
   localparam logic [2:0] RST_CTL      = 3'h0;
   localparam logic [4:0] RST_SLICER   = 5'h17;
   localparam logic [7:0] RST_LEAD     = 8'h00;
   localparam logic [7:0] RST_TRAIL    = 8'h00;
   localparam logic [7:0] RST_TEST_A   = 8'h00;
   localparam logic [7:0] RST_TEST_B   = 8'h00;
   localparam logic [7:0] RST_TEST_C   = 8'h00;
   localparam logic [7:0] RST_TEST_FMT = 8'h00;

   // ****************************************
   // carriers
   // ****************************************
   // live outputs of the activity and polarity detectors
   typedef struct packed {
      logic hs_act;
      logic sog_act;
      logic vs_act;
      logic hs_pol;
      logic vs_pol;
      logic hold_pol;
   } ssc_det_t;

   // one pixel of video data
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } ssc_pix_t;

endpackage

// ===== design/ssc_pin_sync.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module ssc_pin_sync #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // pins and filtered result
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] pin_o
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] out_ff;
   logic [W-1:0] nxt_out;

   // ****************************************
   // agreement filter
   // ****************************************
   // a bit moves only once stages two and three agree; stage one feeds stage two only
   always_comb begin
      for (int i = 0; i < W; i++) begin
         nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
      end
   end

   // synchroniser chain and filtered output
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         out_ff <= '0;
      end else begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         out_ff <= nxt_out;
      end
   end

   assign pin_o = out_ff;

endmodule

// ===== design/ssc_sync_select.sv
// module: sync source selection, separator, hold window and output format register bank
//
// Functional notes
// (RULE1) 12h bit4 picks hsync source under override, and breaks auto ties; 0 is pin
// (RULE2) 12h bit3 set bypasses automatic vertical selection, bit2 then decides
// (RULE3) 12h bit2 under override: 0 vertical pin, 1 separator output
// (RULE4) 12h bit1 picks hold source: 0 external pin, 1 the selected vertical sync
// (RULE5) 12h bit0 low powers the whole device down; reset value one
// (RULE6) while powered down no detector reports any activity
// (RULE7) separator toggles only after counting 13h pixel clocks; reset 32
// (RULE8) host should set separator count above widest horizontal pulse
// (RULE9) 14h bit2 enables scan function; reset zero
// (RULE10) 14h bit1 low uses detected hold polarity, high the user setting
// (RULE11) 14h bit0 low uses detected hsync polarity, high the user setting
// (RULE12) 15h bit7 reads detected hsync polarity, one positive
// (RULE13) 15h bit6 reads detected vsync polarity, one active high
// (RULE14) 15h bit5 reads detected external hold polarity, one positive
// (RULE15) 16h bits 7-3 hold slicer code, 10 mV steps, reset 23
// (RULE16) 17h sets hold lead in line periods before vertical sync
// (RULE17) 18h sets hold trail in line periods after vertical sync
// (RULE18) host writes test registers 1Ah, 1Bh, 1Ch with fixed values
// (RULE19) 1Ch bit1 selects 4:2:2 output, shrinking data lines to 16
// (RULE20) in 4:2:2 green carries luma, red alternates chroma, blue floats
// (RULE21) auto hsync: only one active wins, both or none defer to bit4
// (RULE22) vertical override forces the active vertical choice to bit2
// (RULE23) reset loads every default; status follows live detectors afterwards
`timescale 1ns/1ps

module ssc_sync_select #(
   parameter int LINE_W = 12
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // register access from the serial port
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   // sync pins
   input wire logic hsync_pin_i,
   input wire logic green_embedded_sync_i,
   input wire logic vsync_pin_i,
   input wire logic hold_pin_i,
   // detector results and user polarity settings
   input wire ssc_pkg::ssc_det_t det_i,
   input wire logic user_hs_pol_i,
   input wire logic user_hold_pol_i,
   // video data
   input wire ssc_pkg::ssc_pix_t pix_i,
   output ssc_pkg::ssc_pix_t pix_o,
   output logic blue_oe_o,
   // sync and control results
   output logic active_horizontal_choice_o,
   output logic active_vertical_choice_o,
   output logic hsync_pll_o,
   output logic vsync_o,
   output logic pll_hold_o,
   output logic full_power_down_n_o,
   output logic scan_en_o,
   output logic [4:0] slicer_code_o,
   output logic fmt_422_o
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [3:0] pin_s;

   ssc_pin_sync #(.W(4)) u_pins (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .pin_i({hold_pin_i, vsync_pin_i, green_embedded_sync_i, hsync_pin_i}),
      .pin_o(pin_s)
   );

   logic hs_pin;
   logic sog_pin;
   logic vs_pin;
   logic hold_pin;
   assign hs_pin = pin_s[0];
   assign sog_pin = pin_s[1];
   assign vs_pin = pin_s[2];
   assign hold_pin = pin_s[3];

   // ****************************************
   // register file
   // ****************************************
   logic [7:0] src_ff, thr_ff, lead_ff, trail_ff, tsta_ff, tstb_ff, tstc_ff, fmt_ff;
   logic [2:0] ctl_ff;
   logic [4:0] slc_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_src, nxt_thr, nxt_lead, nxt_trail, nxt_tsta, nxt_tstb, nxt_tstc, nxt_fmt;
   logic [2:0] nxt_ctl;
   logic [4:0] nxt_slc;
   logic [7:0] nxt_rdata;

   // write decode; unmapped or read-only offsets swallow the write
   always_comb begin
      nxt_src = src_ff;
      nxt_thr = thr_ff;
      nxt_ctl = ctl_ff;
      nxt_slc = slc_ff;
      nxt_lead = lead_ff;
      nxt_trail = trail_ff;
      nxt_tsta = tsta_ff;
      nxt_tstb = tstb_ff;
      nxt_tstc = tstc_ff;
      nxt_fmt = fmt_ff;
      if (wr_en_i) begin
         case (addr_i)
            ssc_pkg::OFS_SRC_SEL: nxt_src = wdata_i;
            ssc_pkg::OFS_SEP_THR: nxt_thr = wdata_i; // RULE7
            ssc_pkg::OFS_CTL: nxt_ctl = wdata_i[2:0];
            ssc_pkg::OFS_SLICER: nxt_slc = wdata_i[ssc_pkg::SLC_MSB:ssc_pkg::SLC_LSB]; // RULE15
            ssc_pkg::OFS_LEAD: nxt_lead = wdata_i; // RULE16
            ssc_pkg::OFS_TRAIL: nxt_trail = wdata_i; // RULE17
            ssc_pkg::OFS_TEST_A: nxt_tsta = wdata_i;
            ssc_pkg::OFS_TEST_B: nxt_tstb = wdata_i;
            ssc_pkg::OFS_TEST_C: nxt_tstc = wdata_i;
            ssc_pkg::OFS_TEST_FMT: nxt_fmt = wdata_i; // RULE19
            default: ;
         endcase
      end
   end

   // read mux; reserved bits and unmapped offsets read as zero
   always_comb begin
      nxt_rdata = rdata_ff;
      if (rd_en_i) begin
         case (addr_i)
            ssc_pkg::OFS_SRC_SEL: nxt_rdata = src_ff;
            ssc_pkg::OFS_SEP_THR: nxt_rdata = thr_ff;
            ssc_pkg::OFS_CTL: nxt_rdata = {5'h00, ctl_ff};
            ssc_pkg::OFS_POL_STAT: nxt_rdata = {det_i.hs_pol, det_i.vs_pol, det_i.hold_pol,
                                                5'h00}; // RULE12 RULE13 RULE14
            ssc_pkg::OFS_SLICER: nxt_rdata = {slc_ff, 3'h0};
            ssc_pkg::OFS_LEAD: nxt_rdata = lead_ff;
            ssc_pkg::OFS_TRAIL: nxt_rdata = trail_ff;
            ssc_pkg::OFS_TEST_A: nxt_rdata = tsta_ff;
            ssc_pkg::OFS_TEST_B: nxt_rdata = tstb_ff;
            ssc_pkg::OFS_TEST_C: nxt_rdata = tstc_ff;
            ssc_pkg::OFS_TEST_FMT: nxt_rdata = fmt_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // register storage with documented defaults
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         src_ff <= ssc_pkg::RST_SRC_SEL; // RULE5 RULE23
         thr_ff <= ssc_pkg::RST_SEP_THR;
         ctl_ff <= ssc_pkg::RST_CTL;
         slc_ff <= ssc_pkg::RST_SLICER;
         lead_ff <= ssc_pkg::RST_LEAD;
         trail_ff <= ssc_pkg::RST_TRAIL;
         tsta_ff <= ssc_pkg::RST_TEST_A;
         tstb_ff <= ssc_pkg::RST_TEST_B;
         tstc_ff <= ssc_pkg::RST_TEST_C;
         fmt_ff <= ssc_pkg::RST_TEST_FMT;
         rdata_ff <= 8'h00;
      end else begin
         src_ff <= nxt_src;
         thr_ff <= nxt_thr;
         ctl_ff <= nxt_ctl;
         slc_ff <= nxt_slc;
         lead_ff <= nxt_lead;
         trail_ff <= nxt_trail;
         tsta_ff <= nxt_tsta;
         tstb_ff <= nxt_tstb;
         tstc_ff <= nxt_tstc;
         fmt_ff <= nxt_fmt;
         rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************
   // detector gating and source choice
   // ****************************************
   logic pwr_on;
   logic det_hs, det_sog, det_vs;
   logic nxt_ahs, nxt_avs;
   logic ahs_ff, avs_ff;

   // detectors are dead while powered down, so no activity is reported; polarity status still reads live
   assign pwr_on = src_ff[ssc_pkg::BIT_PWR_N];
   assign det_hs = det_i.hs_act & pwr_on; // RULE6
   assign det_sog = det_i.sog_act & pwr_on; // RULE6
   assign det_vs = det_i.vs_act & pwr_on; // RULE6

   // horizontal choice: override, lone detector, then tie break
   always_comb begin
      if (src_ff[ssc_pkg::BIT_HS_OVR]) begin
         nxt_ahs = src_ff[ssc_pkg::BIT_HS_SEL]; // RULE1
      end else if (det_sog && !det_hs) begin
         nxt_ahs = 1'b1; // RULE21
      end else if (det_hs && !det_sog) begin
         nxt_ahs = 1'b0; // RULE21
      end else begin
         nxt_ahs = src_ff[ssc_pkg::BIT_HS_SEL]; // RULE1 RULE21
      end
   end

   // vertical choice: override, else pin when its activity is seen, else separator output
   always_comb begin
      if (src_ff[ssc_pkg::BIT_VS_OVR]) begin
         nxt_avs = src_ff[ssc_pkg::BIT_VS_SEL]; // RULE2 RULE3 RULE22
      end else begin
         nxt_avs = !det_vs; // RULE2
      end
   end

   // ****************************************
   // sync separator
   // ****************************************
   logic hs_sel;
   logic sep_ff, nxt_sep;
   logic [7:0] sep_cnt_ff, nxt_sep_cnt;

   assign hs_sel = ahs_ff ? sog_pin : hs_pin;

   // low-pass: output follows the input only after it differed for thr counts
   always_comb begin
      nxt_sep = sep_ff;
      nxt_sep_cnt = 8'h00;
      if (pwr_on && (sog_pin != sep_ff)) begin
         if (sep_cnt_ff == thr_ff) begin
            nxt_sep = sog_pin; // RULE7
         end else begin
            nxt_sep_cnt = sep_cnt_ff + 8'h01; // RULE7
         end
      end
   end

   // ****************************************
   // polarity and hold window
   // ****************************************
   logic hs_pol_eff, hold_pol_eff;
   logic hs_norm, vs_norm, hold_norm, vs_raw;
   logic hs_prev_ff, vs_prev_ff;
   logic line_edge, vs_rise, vs_fall;
   logic [LINE_W-1:0] lines_ff, nxt_lines, frame_ff, nxt_frame;
   logic [7:0] post_ff, nxt_post;
   logic pre_on, hold_win, nxt_hold;

   assign hs_pol_eff = ctl_ff[ssc_pkg::BIT_HS_POVR] ? user_hs_pol_i : det_i.hs_pol; // RULE11
   assign hold_pol_eff = ctl_ff[ssc_pkg::BIT_HOLD_POVR] ? user_hold_pol_i
                                                        : det_i.hold_pol; // RULE10
   // everything below works on active-high versions of the syncs
   assign hs_norm = hs_sel ^ ~hs_pol_eff;
   assign vs_raw = avs_ff ? sep_ff : vs_pin;
   assign vs_norm = vs_raw ^ ~det_i.vs_pol;
   assign hold_norm = hold_pin ^ ~hold_pol_eff;
   assign line_edge = hs_norm & ~hs_prev_ff;
   assign vs_rise = vs_norm & ~vs_prev_ff;
   assign vs_fall = ~vs_norm & vs_prev_ff;

   // lead needs the frame length, learned from the previous frame's line count
   assign pre_on = (lead_ff != 8'h00) && (frame_ff != '0) &&
                   ({1'b0, lines_ff} + {{(LINE_W - 7){1'b0}}, lead_ff}
                    >= {1'b0, frame_ff}); // RULE16
   assign hold_win = vs_norm | pre_on | (post_ff != 8'h00);

   // line counter, frame length capture and trail countdown
   always_comb begin
      nxt_lines = lines_ff;
      nxt_frame = frame_ff;
      nxt_post = post_ff;
      if (vs_rise) begin
         nxt_frame = lines_ff;
         nxt_lines = '0;
      end else if (line_edge) begin
         nxt_lines = lines_ff + {{(LINE_W - 1){1'b0}}, 1'b1};
      end
      if (vs_fall) begin
         nxt_post = trail_ff; // RULE17
      end else if (line_edge && post_ff != 8'h00) begin
         nxt_post = post_ff - 8'h01; // RULE17
      end
   end

   // hold source pick
   always_comb begin
      if (src_ff[ssc_pkg::BIT_HOLD_SEL]) begin
         nxt_hold = hold_win; // RULE4
      end else begin
         nxt_hold = hold_norm; // RULE4 RULE10
      end
   end

   // ****************************************
   // output format path
   // ****************************************
   logic fmt422;
   logic phase_ff, nxt_phase;
   ssc_pkg::ssc_pix_t pix_ff, nxt_pix;

   assign fmt422 = fmt_ff[ssc_pkg::BIT_FMT_422];

   // 4:2:2 keeps luma on green and interleaves both chroma inputs on red
   always_comb begin
      nxt_pix = pix_i;
      nxt_phase = 1'b0;
      if (fmt422) begin
         nxt_phase = ~phase_ff;
         nxt_pix.red = phase_ff ? pix_i.blue : pix_i.red; // RULE20
         nxt_pix.blue = 8'h00; // RULE20
      end
   end

   // sync, window and data state
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ahs_ff <= 1'b0;
         avs_ff <= 1'b0;
         sep_ff <= 1'b0;
         sep_cnt_ff <= 8'h00;
         hs_prev_ff <= 1'b0;
         vs_prev_ff <= 1'b0;
         lines_ff <= '0;
         frame_ff <= '0;
         post_ff <= 8'h00;
         phase_ff <= 1'b0;
         pix_ff <= '0;
      end else begin
         ahs_ff <= nxt_ahs;
         avs_ff <= nxt_avs;
         sep_ff <= nxt_sep;
         sep_cnt_ff <= nxt_sep_cnt;
         hs_prev_ff <= hs_norm;
         vs_prev_ff <= vs_norm;
         lines_ff <= nxt_lines;
         frame_ff <= nxt_frame;
         post_ff <= nxt_post;
         phase_ff <= nxt_phase;
         pix_ff <= nxt_pix;
      end
   end

   // registered sync outputs
   logic hs_out_ff, vs_out_ff, hold_out_ff, boe_ff;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hs_out_ff <= 1'b0;
         vs_out_ff <= 1'b0;
         hold_out_ff <= 1'b0;
         boe_ff <= 1'b1;
      end else begin
         hs_out_ff <= hs_norm;
         vs_out_ff <= vs_norm;
         hold_out_ff <= nxt_hold;
         boe_ff <= ~fmt422; // RULE20
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign rdata_o = rdata_ff;
   assign pix_o = pix_ff;
   assign blue_oe_o = boe_ff;
   assign active_horizontal_choice_o = ahs_ff;
   assign active_vertical_choice_o = avs_ff;
   assign hsync_pll_o = hs_out_ff;
   assign vsync_o = vs_out_ff;
   assign pll_hold_o = hold_out_ff;
   assign full_power_down_n_o = src_ff[ssc_pkg::BIT_PWR_N]; // RULE5
   assign scan_en_o = ctl_ff[ssc_pkg::BIT_SCAN_EN]; // RULE9
   assign slicer_code_o = slc_ff; // RULE15
   assign fmt_422_o = fmt_ff[ssc_pkg::BIT_FMT_422]; // RULE19

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   chk_hs_override: assert property ( // RULE1
      src_ff[ssc_pkg::BIT_HS_OVR] |=> ahs_ff == $past(src_ff[ssc_pkg::BIT_HS_SEL]))
      else $error("hsync override ignored");
   chk_hs_auto_lone: assert property ( // RULE21
      !src_ff[ssc_pkg::BIT_HS_OVR] && det_sog && !det_hs |=> ahs_ff)
      else $error("lone green sync not chosen");
   chk_vs_override: assert property ( // RULE22
      src_ff[ssc_pkg::BIT_VS_OVR] ##1 src_ff[ssc_pkg::BIT_VS_OVR]
      |-> avs_ff == $past(src_ff[ssc_pkg::BIT_VS_SEL]))
      else $error("vertical override ignored");
   chk_pd_no_detect: assert property ( // RULE6
      !full_power_down_n_o && !src_ff[ssc_pkg::BIT_HS_OVR] |=>
      ahs_ff == $past(src_ff[ssc_pkg::BIT_HS_SEL]))
      else $error("activity seen while powered down");
   chk_sep_count: assert property ( // RULE7
      sep_ff != $past(sep_ff) |-> $past(sep_cnt_ff) == $past(thr_ff))
      else $error("separator toggled early");
   chk_hold_pin: assert property ( // RULE4
      !src_ff[ssc_pkg::BIT_HOLD_SEL] |=> pll_hold_o == $past(hold_norm))
      else $error("hold not from pin");
   chk_status_read: assert property ( // RULE12
      rd_en_i && addr_i == ssc_pkg::OFS_POL_STAT |=>
      rdata_o[ssc_pkg::BIT_STAT_HS] == $past(det_i.hs_pol) && rdata_o[4:0] == 5'h00)
      else $error("polarity status wrong");
   chk_blue_float: assert property ( // RULE20
      fmt422 |=> !blue_oe_o && pix_o.green == $past(pix_i.green))
      else $error("blue driven in 4:2:2");
   chk_trail_load: assert property ( // RULE17
      vs_fall |=> post_ff == $past(trail_ff))
      else $error("trail count not loaded");
   chk_pwr_write: assert property ( // RULE5
      wr_en_i && addr_i == ssc_pkg::OFS_SRC_SEL |=> full_power_down_n_o == $past(wdata_i[0]))
      else $error("power bit not written");

   cov_sog_only: cover property (det_sog && !det_hs ##1 ahs_ff);
   cov_sep_toggle: cover property (sep_ff != $past(sep_ff));
   cov_hold_window: cover property (src_ff[ssc_pkg::BIT_HOLD_SEL] && post_ff != 8'h00);
   cov_fmt_422: cover property (fmt422 ##1 fmt422 ##1 fmt422);

endmodule

// ===== verification/ssc_host_model.sv
// host controller model issuing single byte accesses to the register bank
`timescale 1ns/1ps

module ssc_host_model (
   // clock
   input wire logic sys_clk_i,
   // register access
   output logic wr_en_o,
   output logic rd_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   // idle bus until the first request
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end

   // one byte write; data is scrambled after the strobe so nothing stale looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      #1 {wr_en_o, addr_o, wdata_o} = {1'b1, a, d};
      @(posedge sys_clk_i);
      #1 {wr_en_o, wdata_o} = {1'b0, ~d};
   endtask

   // one byte read; the registered answer is taken one edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      #1 {rd_en_o, addr_o} = {1'b1, a};
      @(posedge sys_clk_i);
      #1 rd_en_o = 1'b0;
      d = rdata_i;
   endtask

   // start-up programming of the fixed test values and separator count
   task automatic init(input logic fmt);
      wr(8'h13, 8'h20);
      wr(8'h1A, 8'h41);
      wr(8'h1B, 8'h10);
      wr(8'h1C, {6'h2F, fmt, 1'b0});
   endtask
endmodule

// ===== verification/ssc_sync_select_tb_top.sv
// self-checking testbench of the sync select register bank
`timescale 1ns/1ps

module ssc_sync_select_tb_top;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_en, rd_en, boe, active_horizontal_choice, active_vertical_choice, hpll, vso, hold, pwr_n, scan, f422, vo, ho, gs;
   logic [7:0] addr, wdata, rdata, rv, d, r0;
   logic [4:0] slc;
   logic hs_pin = 1'b0, sog_pin = 1'b0, vs_pin = 1'b0, hold_pin = 1'b0;
   logic upol_hs = 1'b0, upol_hold = 1'b0;
   ssc_pkg::ssc_det_t det = '0;
   ssc_pkg::ssc_pix_t pix = '0, po;
   int fail_count = 0;
   int n_tests = 0;

   always #10 sys_clk_i = ~sys_clk_i;

   ssc_host_model i_ssc_host_model (.sys_clk_i(sys_clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en),
      .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));

   ssc_sync_select i_ssc_sync_select (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_en_i(wr_en),
      .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .hsync_pin_i(hs_pin),
      .green_embedded_sync_i(sog_pin), .vsync_pin_i(vs_pin), .hold_pin_i(hold_pin),
      .det_i(det), .user_hs_pol_i(upol_hs), .user_hold_pol_i(upol_hold), .pix_i(pix),
      .pix_o(po), .blue_oe_o(boe), .active_horizontal_choice_o(active_horizontal_choice),
      .active_vertical_choice_o(active_vertical_choice), .hsync_pll_o(hpll), .vsync_o(vso), .pll_hold_o(hold),
      .full_power_down_n_o(pwr_n), .scan_en_o(scan), .slicer_code_o(slc), .fmt_422_o(f422));

   // readable bits of each offset; the status byte follows the live detectors
   function automatic logic [7:0] rmask(input logic [7:0] a);
      if (a == 8'h14) return 8'h07;
      if (a == 8'h16) return 8'hF8;
      return (a >= 8'h12 && a <= 8'h1C && a != 8'h15) ? 8'hFF : 8'h00;
   endfunction

   function automatic logic [7:0] rst_val(input logic [7:0] a);
      if (a == 8'h12) return 8'h01;
      if (a == 8'h13) return 8'h20;
      return (a == 8'h16) ? 8'hB8 : 8'h00;
   endfunction

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      i_ssc_host_model.rd(a, rv);
      chk8(rv, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // hang guard, well past the length of all tests (about 900 cycles)
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end

   // main sequence
   initial begin
      void'($urandom(32'h18E4));
      cyc(10);
      rst_i = 1'b0;
      for (int a = 8'h12; a <= 8'h1D; a++) rdc(8'(a), rst_val(8'(a)));
      $display("test reset_values done");
      // random bytes, odd offsets and read-only status included
      for (int i = 0; i < 40; i++) begin
         r0 = 8'h12 + 8'($urandom % 12);
         d = 8'($urandom);
         i_ssc_host_model.wr(r0, d);
         if (r0 != 8'h15) rdc(r0, d & rmask(r0));
      end
      i_ssc_host_model.init(1'b0);
      rdc(8'h1A, 8'h41);
      $display("test random_rw done");
      // every source choice combination, with and without power
      for (int k = 0; k < 128; k++) begin
         {det.hs_act, det.sog_act, det.vs_act} = {k[3], k[2], k[1] ^ k[3]};
         i_ssc_host_model.wr(8'h12, {2'b00, k[5], k[4], k[1], k[0], 1'b0, k[6]});
         cyc(2);
         gs = k[6] ? {det.hs_act, det.sog_act} == 2'b01 : 1'b0;
         vo = k[1] ? k[0] : !(det.vs_act && k[6]);
         if (k[6] && (det.hs_act ^ det.sog_act) && !k[5]) gs = det.sog_act;
         else gs = k[4];
         chk8({7'h0, active_horizontal_choice}, {7'h0, gs});
         chk8({7'h0, active_vertical_choice}, {7'h0, vo});
         chk8({7'h0, pwr_n}, {7'h0, k[6]});
      end
      $display("test source_choice done");
      // polarity status and polarity overrides with hsync and hold pins held high
      {hs_pin, hold_pin} = 2'b11;
      i_ssc_host_model.wr(8'h12, 8'h21);
      // clear lead and trail so the later hold window follows vsync alone
      i_ssc_host_model.wr(8'h17, 8'h00);
      i_ssc_host_model.wr(8'h18, 8'h00);
      for (int j = 0; j < 8; j++) begin
         {upol_hs, upol_hold} = {2{j[1]}};
         {det.hs_pol, det.vs_pol, det.hold_pol} = {!j[1], j[2], !j[1]};
         i_ssc_host_model.wr(8'h15, 8'hFF);
         i_ssc_host_model.wr(8'h14, {5'h00, j[2], j[0], j[0]});
         cyc(8);
         ho = j[0] ? j[1] : !j[1];
         chk8({6'h0, hold, hpll}, {6'h0, ho, ho});
         chk8({7'h0, scan}, {7'h0, j[2]});
         chk8({7'h0, vso}, {7'h0, !j[2]});
         rdc(8'h15, {!j[1], j[2], !j[1], 5'h00});
      end
      // separator needs 32 counts plus pin latency; hold then taken from vsync
      i_ssc_host_model.wr(8'h12, 8'h23);
      sog_pin = 1'b1;
      cyc(30);
      chk8({6'h0, vso, hold}, 8'h00);
      cyc(10);
      chk8({6'h0, vso, hold}, 8'h03);
      d = 8'($urandom);
      i_ssc_host_model.wr(8'h16, d);
      cyc(1);
      chk8({3'h0, slc}, {3'h0, d[7:3]});
      $display("test polarity_control done");
      // full width pass-through, then reduced format with blue released
      pix = ssc_pkg::ssc_pix_t'({8'h5A, 8'($urandom), 8'hA5});
      cyc(2);
      chk8({7'h0, boe}, 8'h01);
      chk8(po.blue, pix.blue);
      i_ssc_host_model.init(1'b1);
      cyc(2);
      r0 = po.red;
      cyc(1);
      chk8({f422, boe, 6'h0}, 8'h80);
      chk8(po.blue, 8'h00);
      chk8(po.green, pix.green);
      chk8({r0, po.red} == 16'h5AA5 || {r0, po.red} == 16'hA55A, 1'b1);
      $display("test output_format done");
      wrap_up();
   end
endmodule
